// [sgr_pkg.sv]
// Package with register map, field layout and constants of the SDRAM regs.
package sgr_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RATE_W = 16;
  // Register byte offsets.
  localparam logic [11:0] OFS_CONFIG = 12'h000;
  localparam logic [11:0] OFS_REFRESH = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  // Configuration register fields.
  localparam int unsigned CFG_BANK_LSB = 5;
  localparam int unsigned CFG_BANK_MSB = 6;
  localparam int unsigned CFG_CSPAIR_BIT = 3;
  localparam int unsigned CFG_PAGE_LSB = 0;
  localparam int unsigned CFG_PAGE_MSB = 1;
  // Refresh control register fields.
  localparam int unsigned RFC_OFF_BIT = 31;
  localparam int unsigned RFC_RATE_LSB = 0;
  localparam int unsigned RFC_RATE_MSB = 15;
  // Status register fields.
  localparam int unsigned STS_RCNT_LSB = 0;
  localparam int unsigned STS_ICNT_LSB = 16;
  // Reset values.
  localparam logic [1:0] RST_BANK = 2'h0;
  localparam logic RST_CSPAIR = 1'b0;
  localparam logic [1:0] RST_PAGE = 2'h0;
  localparam logic RST_OFF = 1'b1;
  localparam logic [15:0] RST_RATE = 16'h0000;
  // Decoded geometry.
  localparam logic [3:0] COL_BITS_BASE = 4'h8;
  localparam logic [3:0] ONE_BANK = 4'h1;
  typedef enum {SGR_SEL_NONE, SGR_SEL_CFG, SGR_SEL_RFC, SGR_SEL_STS} sgr_sel_e;
endpackage : sgr_pkg

// [sgr_rfsh_if.sv]
// Interface between the register bank and its refresh interval timer.
`timescale 1ns/1ps
`default_nettype none
interface sgr_rfsh_if;
  logic [15:0] rate;
  logic off;
  logic req;
  modport regs (output rate, output off, input req);
  modport timer (input rate, input off, output req);
endinterface : sgr_rfsh_if
`default_nettype wire

// [sgr_refresh_timer.sv]
// Refresh interval counter that raises one autorefresh request per expiry.
`timescale 1ns/1ps
`default_nettype none
module sgr_refresh_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Settings and request
  sgr_rfsh_if.timer rf
);
  logic [15:0] cnt_r;
  logic req_r;

  // --------------------------------------------------------------
  // Interval counter
  // --------------------------------------------------------------
  // A zero rate means no refresh; the counter then idles at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= sgr_pkg::RST_RATE;
    end else if (rf.off || rf.rate == sgr_pkg::RST_RATE) begin
      cnt_r <= rf.rate;
    end else if (cnt_r <= 16'h0001) begin
      cnt_r <= rf.rate;
    end else begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r <= 1'b0;
    end else begin
      req_r <= !rf.off && rf.rate != sgr_pkg::RST_RATE &&
               cnt_r <= 16'h0001;
    end
  end

  assign rf.req = req_r;
endmodule : sgr_refresh_timer
`default_nettype wire

// [sgr_regs.sv]
// APB register bank for SDRAM geometry and refresh control.
//
// Functional notes
// - Bank-count field 0,1,2,3 means 1,2,4,8 internal banks.
// - Writing the bank-count field starts SDRAM initialization.
// - Chip-select pair bit 0 uses first select only; 1 uses both.
// - Page-size field 0..3 selects 8..11 column address bits.
// - Writing the page-size field also starts SDRAM initialization.
// - Reserved configuration bits read zero; writes to them are ignored.
// - Disable bit blocks initialization and refresh; resets to one.
// - Sixteen-bit refresh interval in controller clocks, resets to zero.
// - Autorefresh commands are issued at the programmed interval.
`timescale 1ns/1ps
`default_nettype none
module sgr_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Controller side
  output logic init_start,
  output logic refresh_req,
  output logic init_refresh_off,
  output logic [3:0] bank_count,
  output logic [3:0] column_bits,
  output logic chip_sel0_en,
  output logic chip_sel1_en
);
  logic [1:0] bank_count_sel_r;
  logic chip_select_pair_en_r;
  logic [1:0] column_width_sel_r;
  logic init_refresh_off_r;
  logic [15:0] refresh_rate_r;
  logic [15:0] refresh_cnt_r;
  logic [15:0] init_cnt_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic init_start_r;
  logic refresh_req_r;
  logic [3:0] bank_count_r;
  logic [3:0] column_bits_r;
  logic cs0_en_r;
  logic cs1_en_r;
  logic access;
  logic wr_done;
  logic cfg_geom_wr;
  sgr_pkg::sgr_sel_e sel;

  sgr_rfsh_if rf ();

  function automatic sgr_pkg::sgr_sel_e decode(input logic [11:0] a);
    case (a)
      sgr_pkg::OFS_CONFIG: decode = sgr_pkg::SGR_SEL_CFG;
      sgr_pkg::OFS_REFRESH: decode = sgr_pkg::SGR_SEL_RFC;
      sgr_pkg::OFS_STATUS: decode = sgr_pkg::SGR_SEL_STS;
      default: decode = sgr_pkg::SGR_SEL_NONE;
    endcase
  endfunction : decode

  // --------------------------------------------------------------
  // APB handshake
  // --------------------------------------------------------------
  // One wait state keeps prdata and pready straight from flip-flops.
  assign access = psel && penable;
  assign wr_done = access && pready_r && pwrite;
  assign sel = decode(paddr);
  // Bank and page fields both live in byte lane zero.
  assign cfg_geom_wr = wr_done && sel == sgr_pkg::SGR_SEL_CFG && pstrb[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= access && !pready_r;
      pslverr_r <= access && !pready_r && decode(paddr) ==
                   sgr_pkg::SGR_SEL_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (access && !pready_r && !pwrite) begin
      prdata_r <= 32'h0000_0000;
      case (sel)
        sgr_pkg::SGR_SEL_CFG: begin
          prdata_r[sgr_pkg::CFG_BANK_MSB:sgr_pkg::CFG_BANK_LSB] <=
            bank_count_sel_r;
          prdata_r[sgr_pkg::CFG_CSPAIR_BIT] <= chip_select_pair_en_r;
          prdata_r[sgr_pkg::CFG_PAGE_MSB:sgr_pkg::CFG_PAGE_LSB] <=
            column_width_sel_r;
        end
        sgr_pkg::SGR_SEL_RFC: begin
          prdata_r[sgr_pkg::RFC_OFF_BIT] <= init_refresh_off_r;
          prdata_r[sgr_pkg::RFC_RATE_MSB:sgr_pkg::RFC_RATE_LSB] <=
            refresh_rate_r;
        end
        sgr_pkg::SGR_SEL_STS: begin
          prdata_r[sgr_pkg::STS_RCNT_LSB +: 16] <= refresh_cnt_r;
          prdata_r[sgr_pkg::STS_ICNT_LSB +: 16] <= init_cnt_r;
        end
        default: begin
          prdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Configuration register
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_count_sel_r <= sgr_pkg::RST_BANK;
      chip_select_pair_en_r <= sgr_pkg::RST_CSPAIR;
      column_width_sel_r <= sgr_pkg::RST_PAGE;
    end else if (cfg_geom_wr) begin
      bank_count_sel_r <=
        pwdata[sgr_pkg::CFG_BANK_MSB:sgr_pkg::CFG_BANK_LSB];
      chip_select_pair_en_r <= pwdata[sgr_pkg::CFG_CSPAIR_BIT];
      column_width_sel_r <=
        pwdata[sgr_pkg::CFG_PAGE_MSB:sgr_pkg::CFG_PAGE_LSB];
    end
  end

  // --------------------------------------------------------------
  // Refresh control register
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_refresh_off_r <= sgr_pkg::RST_OFF;
      refresh_rate_r <= sgr_pkg::RST_RATE;
    end else if (wr_done && sel == sgr_pkg::SGR_SEL_RFC) begin
      if (pstrb[3]) begin
        init_refresh_off_r <= pwdata[sgr_pkg::RFC_OFF_BIT];
      end
      if (pstrb[0]) begin
        refresh_rate_r[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        refresh_rate_r[15:8] <= pwdata[15:8];
      end
    end
  end

  // --------------------------------------------------------------
  // Initialization launch and event counters
  // --------------------------------------------------------------
  // A launch is swallowed while the disable bit is set, not deferred.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_start_r <= 1'b0;
    end else begin
      init_start_r <= cfg_geom_wr && !init_refresh_off_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt_r <= 16'h0000;
    end else if (init_start_r) begin
      init_cnt_r <= init_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_cnt_r <= 16'h0000;
    end else if (rf.req) begin
      refresh_cnt_r <= refresh_cnt_r + 16'h0001;
    end
  end

  // --------------------------------------------------------------
  // Refresh timer
  // --------------------------------------------------------------
  assign rf.rate = refresh_rate_r;
  assign rf.off = init_refresh_off_r;

  sgr_refresh_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .rf(rf)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_req_r <= 1'b0;
    end else begin
      refresh_req_r <= rf.req;
    end
  end

  // --------------------------------------------------------------
  // Decoded geometry outputs
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_count_r <= sgr_pkg::ONE_BANK;
      column_bits_r <= sgr_pkg::COL_BITS_BASE;
      cs0_en_r <= 1'b1;
      cs1_en_r <= 1'b0;
    end else begin
      bank_count_r <= sgr_pkg::ONE_BANK << bank_count_sel_r;
      column_bits_r <= sgr_pkg::COL_BITS_BASE +
                       {2'h0, column_width_sel_r};
      cs0_en_r <= 1'b1;
      cs1_en_r <= chip_select_pair_en_r;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign init_start = init_start_r;
  assign refresh_req = refresh_req_r;
  assign init_refresh_off = init_refresh_off_r;
  assign bank_count = bank_count_r;
  assign column_bits = column_bits_r;
  assign chip_sel0_en = cs0_en_r;
  assign chip_sel1_en = cs1_en_r;
endmodule : sgr_regs
`default_nettype wire

// [sgr_regs_checker.sv]
// Concurrent checks on the ports of the SDRAM geometry register bank.
`timescale 1ns/1ps
`default_nettype none
module sgr_regs_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Controller side
  input wire logic init_start,
  input wire logic refresh_req,
  input wire logic init_refresh_off,
  input wire logic [3:0] bank_count,
  input wire logic [3:0] column_bits,
  input wire logic chip_sel0_en,
  input wire logic chip_sel1_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_bank_code: assert property (bank_count inside {4'h1, 4'h2, 4'h4, 4'h8})
    else $error("bank count is not one of 1 2 4 8");
  chk_col_range: assert property (column_bits inside {[4'h8:4'hB]})
    else $error("column width outside 8 to 11");
  chk_cs_first: assert property (chip_sel0_en)
    else $error("first chip select not in use");
  chk_init_cause: assert property (init_start |-> $past(psel && penable && pready && pwrite && paddr == 12'h000 && pstrb[0]))
    else $error("init launch without a config write");
  chk_init_pulse: assert property (init_start |=> !init_start)
    else $error("init launch longer than one cycle");
  // The timer sees the disable bit at once; a request already in its output registers may still leave a cycle or two late.
  chk_init_off: assert property (init_refresh_off && $past(init_refresh_off, 3) |-> !init_start && !refresh_req)
    else $error("init or refresh while disabled");
  chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("access phase not one wait state");
  chk_rsvd_zero: assert property (pready && !pwrite && paddr == 12'h000 |-> !prdata[4] && !prdata[2])
    else $error("reserved config bits read nonzero");
  chk_rfc_rsvd: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata[30:16] == 15'h0)
    else $error("reserved refresh bits read nonzero");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error response without ready");
endmodule : sgr_regs_checker
bind sgr_regs sgr_regs_checker u_sgr_regs_checker (.*);
`default_nettype wire

// [sgr_sdram_model.sv]
// Far side stand-in that counts init launches and measures refresh spacing.
`timescale 1ns/1ps
`default_nettype none
module sgr_sdram_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Commands seen
  input wire logic init_start,
  input wire logic refresh_req,
  // Observations
  output logic [15:0] inits,
  output logic [15:0] refs,
  output logic [15:0] gap
);
  logic [15:0] run_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inits <= 16'h0000;
      refs <= 16'h0000;
      gap <= 16'h0000;
      run_r <= 16'h0000;
    end else begin
      inits <= inits + 16'(init_start);
      refs <= refs + 16'(refresh_req);
      run_r <= refresh_req ? 16'h0000 : run_r + 16'h0001;
      if (refresh_req) begin
        gap <= run_r + 16'h0001;
      end
    end
  end
endmodule : sgr_sdram_model
`default_nettype wire

// [sgr_regs_test.sv]
// Self-checking bench for the SDRAM geometry and refresh register bank.
`timescale 1ns/1ps
`default_nettype none
module sgr_regs_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, v;
  logic [3:0] pstrb, bank_count, column_bits;
  logic init_start, refresh_req, init_refresh_off, cs0, cs1;
  logic [15:0] inits, refs, gap, r, c;
  int bad_count, samples_checked;
  sgr_regs u_sgr_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .init_start(init_start), .refresh_req(refresh_req),
    .init_refresh_off(init_refresh_off), .bank_count(bank_count),
    .column_bits(column_bits), .chip_sel0_en(cs0), .chip_sel1_en(cs1));
  sgr_sdram_model u_sgr_sdram_model (.pclk(pclk), .presetn(presetn),
    .init_start(init_start), .refresh_req(refresh_req), .inits(inits),
    .refs(refs), .gap(gap));
  always #4 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] geo(input int b, input int p, input logic x);
    return {22'h0, 4'(1 << b), 4'(8 + p), 1'b1, x};
  endfunction : geo
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : cmp
  // Holds the request until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    seed = 32'h7B7B;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    cmp(rd, 32'h0, "config reset");
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    cmp(rd, 32'h8000_0000, "refresh reset");
    cmp({22'h0, bank_count, column_bits, cs0, cs1}, geo(0, 0, 1'b0), "geo");
    cmp({31'h0, init_refresh_off}, 32'h1, "off at reset");
    apb(1'b1, 12'h000, 32'h0000_0069, 4'hF);
    repeat (3) @(posedge pclk);
    cmp({16'h0, inits}, 32'h0, "init while off");
    $display("reset test done");
    apb(1'b1, 12'h004, 32'h0, 4'hF);
    repeat (2) @(posedge pclk);
    cmp({31'h0, init_refresh_off}, 32'h0, "off cleared");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v = seed;
      v[6:5] = 2'(i);
      v[1:0] = 2'(3 - i);
      apb(1'b1, 12'h000, v, 4'h1);
      apb(1'b0, 12'h000, 32'h0, 4'h0);
      cmp(rd, v & 32'h0000_006B, "config readback");
      cmp({22'h0, bank_count, column_bits, cs0, cs1}, geo(i, 3 - i, v[3]), "geo");
      cmp({16'h0, inits}, 32'(i + 1), "init count");
    end
    $display("geometry test done");
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      r = (k == 0) ? 16'h0001 : {12'h0, seed[3:0]} + 16'h0002;
      apb(1'b1, 12'h004, {16'hFFF, r}, 4'h3);
      // The old interval runs out before the new one takes over.
      repeat (3 * r + 40) @(posedge pclk);
      cmp({16'h0, gap}, {16'h0, r}, "refresh gap");
    end
    apb(1'b1, 12'h004, 32'hFFFF_0004, 4'hF);
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    cmp(rd, 32'h8000_0004, "refresh readback");
    cmp({31'h0, init_refresh_off}, 32'h1, "off set");
    repeat (4) @(posedge pclk);
    c = refs;
    repeat (40) @(posedge pclk);
    cmp({16'h0, refs}, {16'h0, c}, "refresh while off");
    $display("refresh test done");
    apb(1'b0, 12'h00C, 32'h0, 4'hF);
    cmp({31'h0, er}, 32'h1, "unmapped error");
    cmp(rd, 32'h0, "unmapped data");
    $display("unmapped test done");
    // Status is read-only: the write below must leave both counts intact.
    apb(1'b1, 12'h008, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, 12'h008, 32'h0, 4'h0);
    cmp(rd, {16'h0004, refs}, "status counts");
    $display("status test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    cmp(rd, 32'h8000_0000, "refresh after reset");
    cmp({31'h0, init_refresh_off}, 32'h1, "off after reset");
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    cmp(rd, 32'h0, "config after reset");
    $display("second reset test done");
    close_out();
  end
endmodule : sgr_regs_test
`default_nettype wire
